// >>> i2ct_pkg.sv
package i2ct_pkg;
  // Bus address before the three strap bits are added; 0x82 shifted right once.
  localparam logic [6:0] ADDR_BASE = 7'h41;
  localparam int SEL_W = 3;
  localparam int IDX_W = 7;
  localparam int DEPTH = 128;
  localparam logic [6:0] PAGE_REG = 7'h00;
  localparam logic [6:0] BOOK_REG = 7'h7F;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;
  // Controller line timing: a bus bit is four quarters of 2.5 us.
  localparam int CORE_PERIOD_NS = 50;
  localparam int SCL_QUARTER_NS = 2500;
  localparam int QUARTER_CYC =
    (SCL_QUARTER_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam logic [7:0] QUARTER_LAST = 8'(QUARTER_CYC - 1);
endpackage

// >>> i2ct_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface i2ct_bus_if;
  // Resolved wired-AND levels of the two lines.
  logic scl;
  logic sda;
  // Controller pin drivers.
  logic ctl_scl_o;
  logic ctl_scl_oe;
  logic ctl_sda_o;
  logic ctl_sda_oe;
  // Target pin drivers.
  logic tgt_scl_o;
  logic tgt_scl_oe;
  logic tgt_sda_o;
  logic tgt_sda_oe;

  // Pull-ups give the high level; any enabled low driver wins.
  assign scl = ~((ctl_scl_oe & ~ctl_scl_o) | (tgt_scl_oe & ~tgt_scl_o));
  assign sda = ~((ctl_sda_oe & ~ctl_sda_o) | (tgt_sda_oe & ~tgt_sda_o));

  modport ctl (
    input scl, sda,
    output ctl_scl_o, ctl_scl_oe, ctl_sda_o, ctl_sda_oe
  );
  modport tgt (
    input scl, sda,
    output tgt_scl_o, tgt_scl_oe, tgt_sda_o, tgt_sda_oe
  );
endinterface
`default_nettype wire

// >>> i2ct_target.sv
// Summary of operation
// - Bytes are eight bits, MSB first.
// - Receiver acknowledges each byte in ninth clock.
// - SDA fall/rise while SCL high: start/stop.
// - Data changes only while SCL is low.
// - Acknowledge holds SDA low whole ninth period.
// - First byte: address plus direction; match only.
// - Strap selects address 0x82 to 0x90.
// - Listed addresses are address shifted left once.
// - No limit on bytes per transfer.
// - Reads return successive registers while acknowledged.
// - Writes start at index, then next registers.
// - Controller writes with direction bit zero.
// - Index byte follows address and is acknowledged.
// - Every written data byte is acknowledged.
// - Controller ends write with stop condition.
// - Lines driven low only, else released.
// - Read: index write, repeated start, read address.
// - Controller not-acknowledges last read byte, stops.
// - 128-byte pages, 256-page books, both reset zero.
`timescale 1ns/1ps
`default_nettype none
module i2ct_target (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Address strap.
  input wire logic [i2ct_pkg::SEL_W-1:0] i_addr_sel,
  // Bus lines.
  i2ct_bus_if.tgt bus,
  // Register write report, page selection and own address.
  output logic o_wr_stb,
  output logic [i2ct_pkg::IDX_W-1:0] o_wr_index,
  output logic [7:0] o_wr_data,
  output logic [7:0] o_page,
  output logic [7:0] o_book,
  output logic [6:0] o_own_addr
);
  import i2ct_pkg::*;

  typedef enum logic [2:0] {
    T_IDLE, T_RX, T_ACK, T_TX, T_MACK, T_IGNORE
  } i2ct_tst_e;
  typedef enum logic [1:0] {K_ADDR, K_INDEX, K_DATA} i2ct_kind_e;

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic [SEL_W-1:0] sel_m;
    logic [SEL_W-1:0] sel_s;
    logic [6:0] own;
    i2ct_tst_e st;
    i2ct_kind_e kind;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic [IDX_W-1:0] ptr;
    logic sda_oe;
    logic wr_stb;
    logic [IDX_W-1:0] wr_idx;
    logic [7:0] wr_dat;
    logic [DEPTH-1:0][7:0] mem;
  } i2ct_tgt_s;

  i2ct_tgt_s q_reg;
  i2ct_tgt_s q_next;
  logic rise;
  logic fall;
  logic start_c;
  logic stop_c;

  ////////////////////////////////////////////////////////////////////////
  // Only book 0 page 0 is held here; other pages are reported on the write
  // strobe and read back as zero, while the page and book selectors are
  // always reachable so software can get back.
  function automatic logic visible(input logic [DEPTH-1:0][7:0] m,
                                   input logic [IDX_W-1:0] idx);
    visible = (idx == PAGE_REG) || (idx == BOOK_REG) ||
              ((m[PAGE_REG] == RESET_BYTE) && (m[BOOK_REG] == RESET_BYTE));
  endfunction

  function automatic logic [7:0] rd_byte(input logic [DEPTH-1:0][7:0] m,
                                         input logic [IDX_W-1:0] idx);
    rd_byte = visible(m, idx) ? m[idx] : RESET_BYTE;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  assign rise = q_reg.scl_s & ~q_reg.scl_p;
  assign fall = ~q_reg.scl_s & q_reg.scl_p;
  assign start_c = q_reg.scl_s & q_reg.scl_p &
                   q_reg.sda_p & ~q_reg.sda_s;
  assign stop_c = q_reg.scl_s & q_reg.scl_p &
                  ~q_reg.sda_p & q_reg.sda_s;

  always_comb begin
    logic [7:0] rd;
    rd = rd_byte(q_reg.mem, q_reg.ptr);
    q_next = q_reg;
    q_next.wr_stb = 1'b0;
    q_next.scl_m = bus.scl;
    q_next.scl_s = q_reg.scl_m;
    q_next.scl_p = q_reg.scl_s;
    q_next.sda_m = bus.sda;
    q_next.sda_s = q_reg.sda_m;
    q_next.sda_p = q_reg.sda_s;
    q_next.sel_m = i_addr_sel;
    q_next.sel_s = q_reg.sel_m;
    q_next.own = 7'(ADDR_BASE + {4'h0, q_reg.sel_s});
    if (start_c) begin
      // A start aborts any byte in flight, so nothing partial is stored.
      q_next.st = T_RX;
      q_next.kind = K_ADDR;
      q_next.cnt = 4'h0;
      q_next.sda_oe = 1'b0;
    end else if (stop_c) begin
      q_next.st = T_IDLE;
      q_next.sda_oe = 1'b0;
    end else begin
      case (q_reg.st)
        T_RX: begin
          if (rise) begin
            q_next.sh = {q_reg.sh[6:0], q_reg.sda_s};
            q_next.cnt = q_reg.cnt + 4'h1;
          end else if (fall && q_reg.cnt == ACK_SLOT) begin
            q_next.st = T_ACK;
            q_next.sda_oe = 1'b1;
            case (q_reg.kind)
              K_ADDR: begin
                if (q_reg.sh[7:1] == q_reg.own) begin
                  q_next.rw = q_reg.sh[0];
                  q_next.kind = K_INDEX;
                end else begin
                  q_next.st = T_IGNORE;
                  q_next.sda_oe = 1'b0;
                end
              end
              K_INDEX: begin
                q_next.ptr = q_reg.sh[IDX_W-1:0];
                q_next.kind = K_DATA;
              end
              default: begin
                // Commit only here, once all eight bits are in.
                if (visible(q_reg.mem, q_reg.ptr)) begin
                  q_next.mem[q_reg.ptr] = q_reg.sh;
                end
                q_next.wr_stb = 1'b1;
                q_next.wr_idx = q_reg.ptr;
                q_next.wr_dat = q_reg.sh;
                q_next.ptr = q_reg.ptr + 7'h01;
              end
            endcase
          end
        end
        T_ACK: begin
          if (fall) begin
            // Release on the falling edge so the low covers the full period.
            q_next.cnt = 4'h0;
            q_next.sda_oe = 1'b0;
            if (q_reg.rw == RW_READ) begin
              q_next.st = T_TX;
              q_next.sh = rd;
              q_next.ptr = q_reg.ptr + 7'h01;
              q_next.sda_oe = ~rd[7];
            end else begin
              q_next.st = T_RX;
            end
          end
        end
        T_TX: begin
          if (rise) begin
            q_next.cnt = q_reg.cnt + 4'h1;
          end else if (fall) begin
            if (q_reg.cnt == ACK_SLOT) begin
              q_next.st = T_MACK;
              q_next.sda_oe = 1'b0;
            end else begin
              q_next.sh = {q_reg.sh[6:0], 1'b0};
              q_next.sda_oe = ~q_reg.sh[6];
            end
          end
        end
        T_MACK: begin
          if (rise && q_reg.sda_s) begin
            q_next.st = T_IGNORE;
          end else if (fall) begin
            q_next.st = T_TX;
            q_next.cnt = 4'h0;
            q_next.sh = rd;
            q_next.ptr = q_reg.ptr + 7'h01;
            q_next.sda_oe = ~rd[7];
          end
        end
        default: begin
          q_next.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // The target never stretches the clock, so SCL stays released.
  assign bus.tgt_scl_o = 1'b0;
  assign bus.tgt_scl_oe = 1'b0;
  assign bus.tgt_sda_o = 1'b0;
  assign bus.tgt_sda_oe = q_reg.sda_oe;
  assign o_wr_stb = q_reg.wr_stb;
  assign o_wr_index = q_reg.wr_idx;
  assign o_wr_data = q_reg.wr_dat;
  assign o_page = q_reg.mem[PAGE_REG];
  assign o_book = q_reg.mem[BOOK_REG];
  assign o_own_addr = q_reg.own;
endmodule
`default_nettype wire

// >>> i2ct_controller.sv
`timescale 1ns/1ps
`default_nettype none
module i2ct_controller (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Command.
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  input wire logic i_cmd_read,
  input wire logic [6:0] i_cmd_dev,
  input wire logic [7:0] i_cmd_index,
  input wire logic [7:0] i_cmd_len,
  // Write data.
  input wire logic [7:0] i_wdata,
  output logic o_wdata_take,
  // Read data and completion.
  output logic [7:0] o_rdata,
  output logic o_rdata_valid,
  output logic o_done,
  output logic o_nack,
  // Bus lines.
  i2ct_bus_if.ctl bus
);
  import i2ct_pkg::*;

  typedef enum logic [1:0] {C_IDLE, C_START, C_BIT, C_STOP} i2ct_cst_e;
  typedef enum logic [2:0] {
    P_ADDR_W, P_INDEX, P_WDATA, P_ADDR_R, P_RDATA
  } i2ct_step_e;

  typedef struct packed {
    logic sda_m;
    logic sda_s;
    i2ct_cst_e st;
    i2ct_step_e step;
    logic [1:0] ph;
    logic [7:0] div;
    logic [3:0] bit_i;
    logic [7:0] sh;
    logic scl_oe;
    logic sda_oe;
    logic rd;
    logic [6:0] dev;
    logic [7:0] idx;
    logic [7:0] left;
    logic nack;
    logic done;
    logic take;
    logic rvalid;
    logic [7:0] rdata;
  } i2ct_ctl_s;

  i2ct_ctl_s q_reg;
  i2ct_ctl_s q_next;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic tick;
    logic ld;
    logic tx;
    tick = (q_reg.div == 8'h00) && (q_reg.st != C_IDLE);
    ld = 1'b0;
    tx = (q_reg.step != P_RDATA);
    q_next = q_reg;
    q_next.sda_m = bus.sda;
    q_next.sda_s = q_reg.sda_m;
    q_next.done = 1'b0;
    q_next.take = 1'b0;
    q_next.rvalid = 1'b0;
    q_next.div = tick ? QUARTER_LAST : q_reg.div - 8'h01;
    if (tick) begin
      q_next.ph = q_reg.ph + 2'h1;
    end
    case (q_reg.st)
      C_IDLE: begin
        q_next.div = QUARTER_LAST;
        q_next.ph = 2'h0;
        if (i_cmd_valid) begin
          q_next.st = C_START;
          q_next.step = P_ADDR_W;
          q_next.rd = i_cmd_read;
          q_next.dev = i_cmd_dev;
          q_next.idx = i_cmd_index;
          q_next.nack = 1'b0;
          q_next.left = (i_cmd_read && i_cmd_len == 8'h00) ?
                        8'h01 : i_cmd_len;
        end
      end
      C_START: begin
        // SDA is released before SCL so a repeated start is clean.
        if (tick) begin
          case (q_reg.ph)
            2'h0: q_next.sda_oe = 1'b0;
            2'h1: q_next.scl_oe = 1'b0;
            2'h2: q_next.sda_oe = 1'b1;
            default: begin
              q_next.scl_oe = 1'b1;
              ld = 1'b1;
            end
          endcase
        end
      end
      C_BIT: begin
        if (tick) begin
          case (q_reg.ph)
            2'h0: begin
              if (q_reg.bit_i != ACK_SLOT) begin
                q_next.sda_oe = tx & ~q_reg.sh[7];
              end else begin
                q_next.sda_oe = ~tx & (q_reg.left != 8'h00);
              end
            end
            2'h1: q_next.scl_oe = 1'b1;
            2'h2: q_next.scl_oe = 1'b0;
            default: begin
              q_next.scl_oe = 1'b1;
              q_next.bit_i = q_reg.bit_i + 4'h1;
              if (q_reg.bit_i != ACK_SLOT) begin
                q_next.sh = {q_reg.sh[6:0], q_reg.sda_s};
              end else if (tx && q_reg.sda_s) begin
                q_next.nack = 1'b1;
                q_next.st = C_STOP;
              end else begin
                case (q_reg.step)
                  P_ADDR_W: begin
                    q_next.step = P_INDEX;
                    ld = 1'b1;
                  end
                  P_ADDR_R: begin
                    q_next.step = P_RDATA;
                    ld = 1'b1;
                  end
                  P_RDATA: begin
                    q_next.rdata = q_reg.sh;
                    q_next.rvalid = 1'b1;
                    ld = (q_reg.left != 8'h00);
                    q_next.st = C_STOP;
                  end
                  default: begin
                    if (q_reg.rd) begin
                      q_next.step = P_ADDR_R;
                      q_next.st = C_START;
                    end else begin
                      q_next.step = P_WDATA;
                      ld = (q_reg.left != 8'h00);
                      q_next.st = C_STOP;
                    end
                  end
                endcase
              end
            end
          endcase
        end
      end
      default: begin
        if (tick) begin
          case (q_reg.ph)
            2'h0: q_next.sda_oe = 1'b1;
            2'h1: q_next.scl_oe = 1'b0;
            2'h2: q_next.sda_oe = 1'b0;
            default: begin
              q_next.st = C_IDLE;
              q_next.done = 1'b1;
            end
          endcase
        end
      end
    endcase
    if (ld) begin
      q_next.st = C_BIT;
      q_next.bit_i = 4'h0;
      case (q_next.step)
        P_ADDR_W: q_next.sh = {q_reg.dev, RW_WRITE};
        P_ADDR_R: q_next.sh = {q_reg.dev, RW_READ};
        P_INDEX: q_next.sh = q_reg.idx;
        P_WDATA: begin
          q_next.sh = i_wdata;
          q_next.take = 1'b1;
          q_next.left = q_reg.left - 8'h01;
        end
        default: begin
          q_next.sh = 8'h00;
          q_next.left = q_reg.left - 8'h01;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign bus.ctl_scl_o = 1'b0;
  assign bus.ctl_sda_o = 1'b0;
  assign bus.ctl_scl_oe = q_reg.scl_oe;
  assign bus.ctl_sda_oe = q_reg.sda_oe;
  assign o_cmd_ready = (q_reg.st == C_IDLE);
  assign o_wdata_take = q_reg.take;
  assign o_rdata = q_reg.rdata;
  assign o_rdata_valid = q_reg.rvalid;
  assign o_done = q_reg.done;
  assign o_nack = q_reg.nack;
endmodule
`default_nettype wire

// >>> i2ct_link_chk.sv
`timescale 1ns/1ps
`default_nettype none
module i2ct_link_chk (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Resolved lines.
  input wire logic scl,
  input wire logic sda,
  // Pin drivers of both ends.
  input wire logic ctl_scl_o,
  input wire logic ctl_scl_oe,
  input wire logic ctl_sda_o,
  input wire logic ctl_sda_oe,
  input wire logic tgt_scl_o,
  input wire logic tgt_scl_oe,
  input wire logic tgt_sda_o,
  input wire logic tgt_sda_oe
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  ////////////////////////////////////////////////////////////////////////////
  // Bit position within the current byte, counted on SCL rises since start.
  logic scl_q;
  logic sda_q;
  logic first_reg;
  logic rd_reg;
  logic nack_reg;
  logic hi_seen_reg;
  logic [3:0] bit_reg;

  always_ff @(posedge i_core_clk) begin
    scl_q <= scl;
    sda_q <= sda;
    hi_seen_reg <= tgt_sda_oe & (hi_seen_reg | scl);
    if (!i_rst_b) begin
      first_reg <= 1'b0;
      rd_reg <= 1'b0;
      nack_reg <= 1'b0;
      bit_reg <= 4'h0;
    end else if (scl && scl_q && sda_q && !sda) begin
      first_reg <= 1'b1;
      rd_reg <= 1'b0;
      nack_reg <= 1'b0;
      bit_reg <= 4'h0;
    end else if (scl && !scl_q) begin
      bit_reg <= (bit_reg == 4'h8) ? 4'h0 : bit_reg + 4'h1;
      if (rd_reg && !first_reg && bit_reg == 4'h8) begin
        nack_reg <= sda;
      end
      if (bit_reg == 4'h8) begin
        first_reg <= 1'b0;
      end
      if (first_reg && bit_reg == 4'h7) begin
        rd_reg <= sda;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_drive_low;
    !ctl_scl_o && !ctl_sda_o && !tgt_scl_o && !tgt_sda_o && !tgt_scl_oe;
  endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("a line driver drives a high level");

  property p_tgt_change;
    $changed(tgt_sda_oe) |-> !scl;
  endproperty
  a_tgt_change: assert property (p_tgt_change)
    else $error("target changed SDA while SCL high");

  property p_ack_whole;
    $fell(tgt_sda_oe) |-> hi_seen_reg;
  endproperty
  a_ack_whole: assert property (p_ack_whole)
    else $error("target released SDA before a whole SCL high period");

  property p_tgt_slot;
    $rose(scl) && tgt_sda_oe && !rd_reg |-> bit_reg == 4'h8;
  endproperty
  a_tgt_slot: assert property (p_tgt_slot)
    else $error("target drove SDA outside the acknowledge slot");

  property p_ctl_release;
    $rose(scl) && bit_reg == 4'h8 && (!rd_reg || first_reg) |-> !ctl_sda_oe;
  endproperty
  a_ctl_release: assert property (p_ctl_release)
    else $error("controller held SDA in the target acknowledge slot");

  // After a refused read byte the next rise belongs to the stop, where the
  // controller holds SDA low on purpose, so it is left out here.
  property p_ctl_silent;
    $rose(scl) && rd_reg && !first_reg && !nack_reg &&
      bit_reg != 4'h8 |-> !ctl_sda_oe;
  endproperty
  a_ctl_silent: assert property (p_ctl_silent)
    else $error("controller drove SDA during read data bits");

  property p_start_scl;
    $rose(ctl_sda_oe) && scl |=> scl [*8] ##[30:60] !scl;
  endproperty
  a_start_scl: assert property (p_start_scl)
    else $error("start not followed by SCL low in time");

  property p_stop_idle;
    $fell(ctl_sda_oe) && scl |=> (scl && sda) [*8];
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("bus not idle after stop");

  property p_scl_high;
    $rose(scl) |-> ##40 scl;
  endproperty
  a_scl_high: assert property (p_scl_high)
    else $error("SCL high period too short");
endmodule
`default_nettype wire

// >>> i2c_control_target_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_control_target_port_tb;
  import i2ct_pkg::*;
  localparam int CEIL = 90000;
  logic i_core_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [2:0] i_addr_sel = 3'h0;
  logic i_cmd_valid = 1'b0;
  logic i_cmd_read = 1'b0;
  logic [6:0] i_cmd_dev = 7'h00;
  logic [7:0] i_cmd_index = 8'h00;
  logic [7:0] i_cmd_len = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic o_cmd_ready, o_wdata_take, o_rdata_valid, o_done, o_nack, o_wr_stb;
  logic [7:0] o_rdata, o_wr_data, o_page, o_book;
  logic [6:0] o_wr_index, o_own_addr;
  logic [7:0] wq[$], rq[$], wd[$], eq[$];
  logic [6:0] wi[$];
  logic [6:0] dev_ok;
  logic [6:0] dev_bad;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  i2ct_bus_if bus_if();
  i2ct_target i2ct_target_inst (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .i_addr_sel(i_addr_sel), .bus(bus_if), .o_wr_stb(o_wr_stb),
    .o_wr_index(o_wr_index), .o_wr_data(o_wr_data), .o_page(o_page),
    .o_book(o_book), .o_own_addr(o_own_addr));
  i2ct_controller i2ct_controller_inst (.i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b), .i_cmd_valid(i_cmd_valid), .o_cmd_ready(o_cmd_ready),
    .i_cmd_read(i_cmd_read), .i_cmd_dev(i_cmd_dev),
    .i_cmd_index(i_cmd_index), .i_cmd_len(i_cmd_len), .i_wdata(i_wdata),
    .o_wdata_take(o_wdata_take), .o_rdata(o_rdata),
    .o_rdata_valid(o_rdata_valid), .o_done(o_done), .o_nack(o_nack),
    .bus(bus_if));
  i2ct_link_chk i2ct_link_chk_inst (.i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b), .scl(bus_if.scl), .sda(bus_if.sda),
    .ctl_scl_o(bus_if.ctl_scl_o), .ctl_scl_oe(bus_if.ctl_scl_oe),
    .ctl_sda_o(bus_if.ctl_sda_o), .ctl_sda_oe(bus_if.ctl_sda_oe),
    .tgt_scl_o(bus_if.tgt_scl_o), .tgt_scl_oe(bus_if.tgt_scl_oe),
    .tgt_sda_o(bus_if.tgt_sda_o), .tgt_sda_oe(bus_if.tgt_sda_oe));

  always #25 i_core_clk = ~i_core_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rd;
    chk(8'(rq.size()), 8'(eq.size()));
    foreach (eq[k]) chk(rq[k], eq[k]);
  endtask

  task automatic do_reset;
    @(negedge i_core_clk);
    i_rst_b = 1'b0;
    repeat (6) @(negedge i_core_clk);
    i_rst_b = 1'b1;
    repeat (8) @(negedge i_core_clk);
  endtask

  // One command; write bytes come from wq, read bytes land in rq.
  task automatic xfer(input logic rd, input logic [6:0] dev,
                      input logic [7:0] idx, input int n);
    int k;
    k = 0;
    rq.delete();
    @(negedge i_core_clk);
    i_cmd_read = rd;
    i_cmd_dev = dev;
    i_cmd_index = idx;
    i_cmd_len = 8'(n);
    i_wdata = (wq.size() > 0) ? wq[0] : 8'h00;
    chk({7'h00, o_cmd_ready}, 8'h01);
    i_cmd_valid = 1'b1;
    @(negedge i_core_clk);
    i_cmd_valid = 1'b0;
    chk({7'h00, o_cmd_ready}, 8'h00);
    while (o_done !== 1'b1) begin
      @(negedge i_core_clk);
      if (o_wdata_take === 1'b1) begin
        k++;
        i_wdata = (k < wq.size()) ? wq[k] : 8'h00;
      end
      if (o_rdata_valid === 1'b1) begin
        rq.push_back(o_rdata);
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Outputs are registered, so the falling edge sees them settled.
  always @(negedge i_core_clk) begin
    if (o_wr_stb === 1'b1) begin
      wi.push_back(o_wr_index);
      wd.push_back(o_wr_data);
    end
  end

  always @(posedge i_core_clk) begin
    cyc = cyc + 1;
    if (cyc == CEIL) begin
      err_count = err_count + 1;
      complete_run();
    end
  end

  initial begin
    dev_ok = 7'(8'h90 >> 1);
    dev_bad = 7'(8'h82 >> 1);
    do_reset();
    chk(o_page, 8'h00);
    chk(o_book, 8'h00);
    for (int s = 0; s < 8; s++) begin
      i_addr_sel = 3'(s);
      repeat (6) @(negedge i_core_clk);
      chk({1'b0, o_own_addr}, 8'(8'h82 + 2 * s) >> 1);
    end
    wq = '{8'hA5, 8'h3C, 8'h81, 8'h7E};
    xfer(1'b0, dev_ok, 8'h10, 4);
    chk({7'h00, o_nack}, 8'h00);
    chk(8'(wi.size()), 8'h04);
    foreach (wq[k]) begin
      chk({1'b0, wi[k]}, 8'(8'h10 + k));
      chk(wd[k], wq[k]);
    end
    eq = wq;
    xfer(1'b1, dev_ok, 8'h10, 4);
    chk_rd();
    wi.delete();
    wd.delete();
    xfer(1'b0, dev_bad, 8'h10, 1);
    chk({7'h00, o_nack}, 8'h01);
    chk(8'(wi.size()), 8'h00);
    xfer(1'b1, dev_bad, 8'h10, 1);
    chk({7'h00, o_nack}, 8'h01);
    chk(8'(rq.size()), 8'h00);
    wq = '{8'h5A, 8'h02, 8'h03};
    xfer(1'b0, dev_ok, 8'h7E, 3);
    chk({1'b0, wi[2]}, 8'h00);
    chk(o_book, 8'h02);
    chk(o_page, 8'h03);
    eq = '{8'h00, 8'h02, 8'h03};
    wq.delete();
    xfer(1'b1, dev_ok, 8'h7E, 3);
    chk_rd();
    do_reset();
    chk(o_book, 8'h00);
    chk(o_page, 8'h00);
    eq = '{8'h00, 8'h00};
    xfer(1'b1, dev_ok, 8'h7F, 2);
    chk_rd();
    complete_run();
  end
endmodule
`default_nettype wire
